// ---- src/ssoc_top.sv ----
// Local design decisions: the AXI4-Lite register port and the address map.
`include "ssoc_defines.svh"

module ssoc_top (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Serial pins and the general I/O values used when the port is off.
  input wire ssoc_pkg::ssoc_pin_in_t pins_in,
  input wire ssoc_pkg::ssoc_pin_out_t gpio_pins_in,
  output ssoc_pkg::ssoc_pin_out_t pins_out,
  // Interrupt.
  output logic irq_out
);

  // ============================================================
  // Helpers.

  // Master modes are the low codes, slave modes two fixed codes.
  function automatic logic is_master(input logic [3:0] mode);
    is_master = (mode <= `SSOC_MODE_MASTER_LAST);
  endfunction : is_master

  function automatic logic is_slave(input logic [3:0] mode);
    is_slave = (mode == `SSOC_MODE_SLAVE_A) || (mode == `SSOC_MODE_SLAVE_B);
  endfunction : is_slave

  function automatic logic [7:0] half_count(input logic [1:0] sel);
    unique case (sel)
      2'h0: half_count = `SSOC_HALF_DIV0;
      2'h1: half_count = `SSOC_HALF_DIV1;
      2'h2: half_count = `SSOC_HALF_DIV2;
      2'h3: half_count = `SSOC_HALF_DIV3;
    endcase
  endfunction : half_count

  // ============================================================
  // Pin synchronisers.

  logic sck_s1_r, sck_s2_r, sck_s3_r, sdi_s1_r, sdi_s2_r;

  // Two flops before any logic; the third flop only remembers the settled level.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end else begin
      sck_s1_r <= pins_in.sck_in;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      sdi_s1_r <= pins_in.sdi_in;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // ============================================================
  // Bus slave.

  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_do, rd_do, rd_buf;

  // Core state, declared here because the read mux shows it.
  ssoc_pkg::ssoc_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] rxbuf_r, rxbuf_nxt, shreg_r, shreg_nxt, div_r, div_nxt;
  logic [2:0] bitcnt_r, bitcnt_nxt, irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic full_r, full_nxt, busy_r, busy_nxt, sck_lvl_r, sck_lvl_nxt, rxbit_r, rxbit_nxt;

  assign s_axi_awready_out = !aw_have_r && !bvalid_r;
  assign s_axi_wready_out = !w_have_r && !bvalid_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;

  // Address and data are held separately, so either may arrive first.
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt = w_have_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r && !s_axi_bready_in;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready_in;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    wr_do = aw_have_r && w_have_r;
    rd_do = s_axi_arvalid_in && !rvalid_r;
    rd_buf = rd_do && (s_axi_araddr_in == `SSOC_OFF_BUF);
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata_in;
      w_strb_nxt = s_axi_wstrb_in;
    end
    if (wr_do) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      unique case (aw_addr_r)
        `SSOC_OFF_CTRL, `SSOC_OFF_BUF, `SSOC_OFF_STAT, `SSOC_OFF_IRQ_STAT,
        `SSOC_OFF_IRQ_MASK: bresp_nxt = `SSOC_RESP_OKAY;
        default: bresp_nxt = `SSOC_RESP_SLVERR;
      endcase
    end
    if (rd_do) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `SSOC_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr_in)
        `SSOC_OFF_CTRL: rdata_nxt[7:0] = ctrl_r;
        `SSOC_OFF_BUF: rdata_nxt[7:0] = rxbuf_r;
        `SSOC_OFF_STAT: begin
          rdata_nxt[`SSOC_STAT_FULL_BIT] = full_r;
          rdata_nxt[`SSOC_STAT_BUSY_BIT] = busy_r || (bitcnt_r != 3'h0);
        end
        `SSOC_OFF_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
        `SSOC_OFF_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
        default: rresp_nxt = `SSOC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `SSOC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `SSOC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ============================================================
  // Serial core.

  logic master_on, slave_on, wr_lane0, lead, trail, done_ev, ovf_ev, col_ev;
  logic [7:0] rx_byte;

  assign master_on = ctrl_r.port_enable_bit && is_master(ctrl_r.mode_select);
  assign slave_on = ctrl_r.port_enable_bit && is_slave(ctrl_r.mode_select);
  assign wr_lane0 = wr_do && w_strb_r[0];

  // Register writes, bit shifting and flag events are one group so that
  // hardware sets can win over software clears in the same cycle.
  always_comb begin
    ctrl_nxt = ctrl_r;
    rxbuf_nxt = rxbuf_r;
    shreg_nxt = shreg_r;
    div_nxt = div_r;
    bitcnt_nxt = bitcnt_r;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    full_nxt = full_r && !rd_buf;
    busy_nxt = busy_r;
    sck_lvl_nxt = sck_lvl_r;
    rxbit_nxt = rxbit_r;
    lead = 1'b0;
    trail = 1'b0;
    done_ev = 1'b0;
    ovf_ev = 1'b0;
    col_ev = 1'b0;
    rx_byte = {shreg_r[6:0], rxbit_r};
    if (wr_lane0) begin
      unique case (aw_addr_r)
        `SSOC_OFF_CTRL: ctrl_nxt = w_data_r[7:0];
        `SSOC_OFF_BUF: begin
          if (busy_r || bitcnt_r != 3'h0) begin
            col_ev = 1'b1;
          end else if (master_on || slave_on) begin
            shreg_nxt = w_data_r[7:0];
            busy_nxt = master_on;
            div_nxt = 8'h00;
          end
        end
        `SSOC_OFF_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~w_data_r[2:0];
        `SSOC_OFF_IRQ_MASK: irq_mask_nxt = w_data_r[2:0];
        default: ;
      endcase
    end
    // Master clock: toggle on each half-period, leaving idle is the leading edge.
    if (busy_r && master_on) begin
      if (div_r == half_count(ctrl_r.mode_select[1:0]) - 8'h01) begin
        div_nxt = 8'h00;
        sck_lvl_nxt = !sck_lvl_r;
        lead = (sck_lvl_r == ctrl_r.clock_idle_polarity);
        trail = !lead;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end else if (slave_on) begin
      lead = (sck_s3_r == ctrl_r.clock_idle_polarity) && (sck_s2_r != sck_s3_r);
      trail = (sck_s3_r != ctrl_r.clock_idle_polarity) && (sck_s2_r != sck_s3_r);
    end
    if (!busy_r) begin
      sck_lvl_nxt = ctrl_r.clock_idle_polarity;
    end
    // Sample on the leading edge, shift on the trailing edge.
    if (lead) begin
      rxbit_nxt = sdi_s2_r;
    end
    if (trail) begin
      shreg_nxt = rx_byte;
      bitcnt_nxt = bitcnt_r + 3'h1;
      if (bitcnt_r == `SSOC_LAST_BIT) begin
        busy_nxt = 1'b0;
        if (slave_on && full_r && !rd_buf) begin
          ovf_ev = 1'b1;
        end else begin
          rxbuf_nxt = rx_byte;
          full_nxt = 1'b1;
          done_ev = 1'b1;
        end
      end
    end
    // A disabled port forgets any partial byte.
    if (!ctrl_r.port_enable_bit) begin
      busy_nxt = 1'b0;
      bitcnt_nxt = 3'h0;
    end
    // Sticky flags: a set in the same cycle beats the software clear.
    ctrl_nxt.write_collision_flag = ctrl_nxt.write_collision_flag || col_ev;
    ctrl_nxt.receive_overflow_flag = ctrl_nxt.receive_overflow_flag || ovf_ev;
    irq_stat_nxt[`SSOC_IRQ_DONE_BIT] = irq_stat_nxt[`SSOC_IRQ_DONE_BIT] || done_ev;
    irq_stat_nxt[`SSOC_IRQ_OVF_BIT] = irq_stat_nxt[`SSOC_IRQ_OVF_BIT] || ovf_ev;
    irq_stat_nxt[`SSOC_IRQ_WRITE_COLLISION_FLAG_BIT] = irq_stat_nxt[`SSOC_IRQ_WRITE_COLLISION_FLAG_BIT] || col_ev;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= `SSOC_CTRL_RESET;
      rxbuf_r <= 8'h00;
      shreg_r <= 8'h00;
      div_r <= 8'h00;
      bitcnt_r <= 3'h0;
      irq_stat_r <= `SSOC_IRQ_RESET;
      irq_mask_r <= `SSOC_IRQ_RESET;
      full_r <= 1'b0;
      busy_r <= 1'b0;
      sck_lvl_r <= 1'b0;
      rxbit_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rxbuf_r <= rxbuf_nxt;
      shreg_r <= shreg_nxt;
      div_r <= div_nxt;
      bitcnt_r <= bitcnt_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      full_r <= full_nxt;
      busy_r <= busy_nxt;
      sck_lvl_r <= sck_lvl_nxt;
      rxbit_r <= rxbit_nxt;
    end
  end

  // ============================================================
  // Pin ownership and interrupt.

  // The port owns the pins only when enabled in a known mode; otherwise the
  // general I/O values pass through untouched.
  always_comb begin
    pins_out = gpio_pins_in;
    if (master_on || slave_on) begin
      pins_out.sdo_out = shreg_r[7];
      pins_out.sdo_oe_n = 1'b0;
      pins_out.sck_out = sck_lvl_r;
      pins_out.sck_oe_n = !master_on;
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

endmodule : ssoc_top

// ---- common/ssoc_defines.svh ----
`ifndef SSOC_DEFINES_SVH
`define SSOC_DEFINES_SVH
// What this block does
// - A slave byte completing while the buffer is still full sets the overflow flag.
// - On overflow the shifted byte is dropped and the buffer keeps its old byte.
// - Overflow can be raised only while the port works as slave.
// - Master transfers start only on a buffer write and never raise overflow.
// - Setting the enable bit in a master mode hands the clock and data-out pins to the port; in a slave mode only data-out.
// - The clock polarity bit sets the idle clock level: one high, zero low.
// - Buffer full is set when a received byte loads and cleared once read.

// ============================================================
// Register byte offsets on the AXI4-Lite bus.
`define SSOC_OFF_CTRL 8'h00
`define SSOC_OFF_BUF 8'h04
`define SSOC_OFF_STAT 8'h08
`define SSOC_OFF_IRQ_STAT 8'h0c
`define SSOC_OFF_IRQ_MASK 8'h10

// ============================================================
// Control register fields and reset value.
`define SSOC_CTRL_WRITE_COLLISION_FLAG_BIT 7
`define SSOC_CTRL_OVF_BIT 6
`define SSOC_CTRL_EN_BIT 5
`define SSOC_CTRL_CKP_BIT 4
`define SSOC_CTRL_RESET 8'h00

// ============================================================
// Status and interrupt bit positions.
`define SSOC_STAT_FULL_BIT 0
`define SSOC_STAT_BUSY_BIT 1
`define SSOC_IRQ_DONE_BIT 0
`define SSOC_IRQ_OVF_BIT 1
`define SSOC_IRQ_WRITE_COLLISION_FLAG_BIT 2
`define SSOC_IRQ_RESET 3'h0

// ============================================================
// Mode field codes and master half-period counts in core clocks.
`define SSOC_MODE_MASTER_LAST 4'h3
`define SSOC_MODE_SLAVE_A 4'h4
`define SSOC_MODE_SLAVE_B 4'h5
`define SSOC_HALF_DIV0 8'h02
`define SSOC_HALF_DIV1 8'h08
`define SSOC_HALF_DIV2 8'h20
`define SSOC_HALF_DIV3 8'h80
`define SSOC_LAST_BIT 3'h7

// ============================================================
// Bus answer codes.
`define SSOC_RESP_OKAY 2'h0
`define SSOC_RESP_SLVERR 2'h2
`endif

// ---- common/ssoc_pkg.sv ----
package ssoc_pkg;
  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic write_collision_flag;
    logic receive_overflow_flag;
    logic port_enable_bit;
    logic clock_idle_polarity;
    logic [3:0] mode_select;
  } ssoc_ctrl_t;

  // Signals driven towards the serial pins.
  typedef struct packed {
    logic sck_out;
    logic sck_oe_n;
    logic sdo_out;
    logic sdo_oe_n;
  } ssoc_pin_out_t;

  // Signals sampled from the serial pins.
  typedef struct packed {
    logic sck_in;
    logic sdi_in;
  } ssoc_pin_in_t;
endpackage : ssoc_pkg

// ---- sim/ssoc_monitor.sv ----
module ssoc_monitor (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Register bus.
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Serial pins and interrupt.
  input wire ssoc_pkg::ssoc_pin_out_t pins_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Bus and pin checks.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
  a_aw_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  a_bad_addr: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 8'h10
    |=> s_axi_rresp_out == 2'h2) else $error("unmapped read not refused");
  a_master_pins: assert property (!pins_out.sck_oe_n |-> !pins_out.sdo_oe_n)
    else $error("master clock driven without data out");
  // The fastest divider holds each clock level two cycles.
  a_sck_half: assert property (!pins_out.sck_oe_n && !$past(pins_out.sck_oe_n)
    && $changed(pins_out.sck_out) |=> $stable(pins_out.sck_out)) else $error("clock too fast");
  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_irq: cover property ($rose(irq_out));
  c_sck: cover property (!pins_out.sck_oe_n && $changed(pins_out.sck_out));
endmodule : ssoc_monitor

// ---- sim/ssoc_far_end.sv ----
module ssoc_far_end (
  // Clock and setup.
  input wire logic core_clk_in,
  input wire logic idle_in,
  input wire logic echo_in,
  input wire logic sdo_in,
  // Lines towards the port.
  output logic sck_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  logic sck_r = 1'b0;
  logic sdi_r = 1'b0;
  // Clock rests at its idle level outside a byte; as a slave it echoes data out.
  assign sck_out = busy ? sck_r : idle_in;
  assign sdi_out = echo_in ? sdo_in : sdi_r;
  // One byte as master, MSB first; data moves on the trailing edge so it is
  // settled long before the port samples on the leading one.
  task automatic send(input logic [7:0] b);
    busy <= 1'b1;
    sck_r <= idle_in;
    for (int i = 7; i >= 0; i--) begin
      sdi_r <= b[i];
      repeat (10) @(posedge core_clk_in);
      sck_r <= !idle_in;
      repeat (10) @(posedge core_clk_in);
      sck_r <= idle_in;
    end
    repeat (10) @(posedge core_clk_in);
    busy <= 1'b0;
    sdi_r <= !b[0]; // Released line shows the inverse of the last bit.
  endtask : send
endmodule : ssoc_far_end

// ---- sim/sync_serial_overflow_control_tb.sv ----
`include "ssoc_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module sync_serial_overflow_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, q;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_out, far_sck, far_sdi;
  logic [1:0] bresp, rresp, resp_q;
  logic [31:0] rdata;
  ssoc_pkg::ssoc_pin_in_t pins_in;
  ssoc_pkg::ssoc_pin_out_t pins_out;
  ssoc_pkg::ssoc_pin_out_t gpio = 4'h7;
  int err_total = 0, check_count = 0, cycles = 0;

  // ============================================================
  // Clock, wire resolution and parts.
  initial forever #4 core_clk_in = !core_clk_in;
  assign pins_in = {(pins_out.sck_oe_n ? far_sck : pins_out.sck_out), far_sdi};
  ssoc_top uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pins_in(pins_in),
    .gpio_pins_in(gpio), .pins_out(pins_out), .irq_out(irq_out));
  ssoc_far_end far (.core_clk_in(core_clk_in), .idle_in(1'b0), .echo_in(!pins_out.sck_oe_n),
    .sdo_in(pins_out.sdo_out), .sck_out(far_sck), .sdi_out(far_sdi));

  // ============================================================
  // Bus tasks; handshakes are judged at the falling edge, where nothing moves.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, done;
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge core_clk_in);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      resp_q = bresp;
      @(posedge core_clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!done);
    // Ready stays high, so a following call never drops and raises it in one step.
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, done;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge core_clk_in);
      ta = arvalid && arready;
      done = rvalid;
      q = rdata;
      resp_q = rresp;
      @(posedge core_clk_in);
      if (ta) arvalid <= 1'b0;
    end while (!done);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(q, {24'h000000, e})
  endtask : rc
  // Polling is bounded so a stuck flag ends in a mismatch, not a hang.
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int n = 0; n < 300; n++) begin
      rd(a);
      if (q[b] === v) break;
    end
    `CHK(q[b], v)
  endtask : poll
  task automatic chk_pins(input logic [3:0] m, input logic [3:0] e);
    @(negedge core_clk_in);
    `CHK(pins_out & m, e)
    @(posedge core_clk_in);
  endtask : chk_pins
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Cut a hang short after far more cycles than the tests need.
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  // ============================================================
  // Test sequence.
  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    chk_pins(4'hf, 4'h7);
    rc(`SSOC_OFF_CTRL, `SSOC_CTRL_RESET);
    rc(8'h14, 8'h00);
    `CHK(resp_q, `SSOC_RESP_SLVERR)
    wr(8'h14, 8'hff);
    `CHK(resp_q, `SSOC_RESP_SLVERR)
    wr(`SSOC_OFF_IRQ_MASK, 8'h04);
    wr(`SSOC_OFF_CTRL, 8'h31);
    chk_pins(4'hd, 4'h8);
    wr(`SSOC_OFF_BUF, 8'ha5);
    wr(`SSOC_OFF_BUF, 8'h5a);
    `CHK(irq_out, 1'b1)
    poll(`SSOC_OFF_STAT, `SSOC_STAT_FULL_BIT, 1'b1);
    wr(`SSOC_OFF_BUF, 8'h3c);
    poll(`SSOC_OFF_STAT, `SSOC_STAT_BUSY_BIT, 1'b0);
    chk_pins(4'h8, 4'h8);
    rc(`SSOC_OFF_CTRL, 8'hb1);
    rc(`SSOC_OFF_BUF, 8'h3c);
    rc(`SSOC_OFF_STAT, 8'h00);
    rc(`SSOC_OFF_IRQ_STAT, 8'h05);
    wr(`SSOC_OFF_IRQ_STAT, 8'h07);
    `CHK(irq_out, 1'b0)
    wr(`SSOC_OFF_CTRL, 8'h20);
    chk_pins(4'h8, 4'h0);
    wr(`SSOC_OFF_BUF, 8'h96);
    poll(`SSOC_OFF_STAT, `SSOC_STAT_BUSY_BIT, 1'b0);
    rc(`SSOC_OFF_STAT, 8'h01);
    rc(`SSOC_OFF_CTRL, 8'h20);
    rd(`SSOC_OFF_BUF);
    wr(`SSOC_OFF_CTRL, 8'h24);
    chk_pins(4'h5, 4'h4);
    far.send(8'hc3);
    poll(`SSOC_OFF_STAT, `SSOC_STAT_FULL_BIT, 1'b1);
    wr(`SSOC_OFF_CTRL, 8'h25);
    far.send(8'h81);
    poll(`SSOC_OFF_CTRL, `SSOC_CTRL_OVF_BIT, 1'b1);
    rc(`SSOC_OFF_CTRL, 8'h65);
    rc(`SSOC_OFF_BUF, 8'hc3);
    rc(`SSOC_OFF_IRQ_STAT, 8'h03);
    wr(`SSOC_OFF_IRQ_MASK, 8'h02);
    rc(`SSOC_OFF_IRQ_MASK, 8'h02);
    `CHK(irq_out, 1'b1)
    wr(`SSOC_OFF_IRQ_STAT, 8'h02);
    `CHK(irq_out, 1'b0)
    wr(`SSOC_OFF_CTRL, 8'h00);
    rc(`SSOC_OFF_CTRL, 8'h00);
    chk_pins(4'hf, 4'h7);
    summarize();
  end
endmodule : sync_serial_overflow_control_tb

bind ssoc_top ssoc_monitor mon (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .pins_out(pins_out), .irq_out(irq_out));
